/* File: rtl/cirb_top.sv */
// Camera inquiry register bank answering 1394 quadlet requests
`timescale 1ns/1ps
// Functional notes
// RULE1: Initialize bit resets camera, frees lock, reloads
// RULE2: Initialize bit clears itself after being set
// RULE3: Decode from bus ID, node ID, fixed base
// RULE4: Register address is base plus byte offset
// RULE5: Bit 0 is the quadlet MSB
// RULE6: Format inquiry: bits 0,1,2,7 set
// RULE7: Mode bit reads 1 only when supported
// RULE8: Format 0 modes 1,5,6; colour adds 3
// RULE9: Format 1 modes 2,5,6,7; colour adds 0,3
// RULE10: Format 2 modes 2,6; colour adds 0
// RULE11: Format 7 mode 0; colour adds 1
// RULE12: Host rechecks settings after leaving Format 7
// RULE13: Host rechecks settings after entering Format 7
// RULE14: Configuration ROM follows camera register standard
// RULE15: Unmapped reads return zero, writes ignored
// RULE16: Reinit loads startup channel, factory by default
// RULE17: Parameter selects monochrome or colour contents
module cirb_top
   import cirb_pkg::*;
#(
   parameter bit COLOUR_VARIANT = 1'b0
) (
   input  wire logic                 mclk,
   input  wire logic                 reset_n,
   input  wire logic [BUS_ID_W-1:0]  local_bus_id,
   input  wire logic [NODE_ID_W-1:0] local_node_id,
   input  wire logic                 req_valid,
   input  wire logic                 req_write,
   input  wire logic [BUS_ID_W-1:0]  req_bus_id,
   input  wire logic [NODE_ID_W-1:0] req_node_id,
   input  wire logic [OFS_W-1:0]     req_offset,
   input  wire logic [31:0]          req_wdata,
   input  wire logic [CHAN_W-1:0]    startup_channel,
   input  wire logic                 load_done,
   output logic                      rsp_valid,
   output logic [31:0]               rsp_rdata,
   output logic                      cam_reset_n,
   output logic                      lock_release,
   output logic                      load_req,
   output logic [CHAN_W-1:0]         load_channel,
   output logic                      init_busy
);
   // Inquiry contents chosen per variant at build time
   localparam logic [31:0] F0_VAL = COLOUR_VARIANT ? F0_COLOUR : F0_MONO; // RULE17
   localparam logic [31:0] F1_VAL = COLOUR_VARIANT ? F1_COLOUR : F1_MONO; // RULE17
   localparam logic [31:0] F2_VAL = COLOUR_VARIANT ? F2_COLOUR : F2_MONO; // RULE17
   localparam logic [31:0] F7_VAL = COLOUR_VARIANT ? F7_COLOUR : F7_MONO; // RULE17

   logic                rst_n;
   logic                node_hit;
   logic                in_window;
   logic [WIN_BITS-1:0] rel_ofs;
   logic                req_taken;
   logic                init_write;
   logic [31:0]         read_word;
   logic                init_reg;
   logic                init_next;
   logic                seq_ack;

   // Reset release through two flops
   cirb_rst_sync u_rst_sync (
      .mclk       (mclk),
      .reset_n    (reset_n),
      .rst_n_sync (rst_n)
   );

   // Request addressed to this node, split into window and byte offset
   assign node_hit  = (req_bus_id == local_bus_id) && (req_node_id == local_node_id); // RULE3
   assign in_window = (req_offset[OFS_W-1:WIN_BITS] == INQ_BASE[OFS_W-1:WIN_BITS]); // RULE3
   assign rel_ofs   = req_offset[WIN_BITS-1:0]; // RULE4
   assign req_taken = req_valid && node_hit;

   // Only a write with the MSB-numbered bit 0 set starts a reinitialisation
   assign init_write = req_taken && req_write && in_window
                       && (rel_ofs == OFS_INIT) && req_wdata[INIT_POS]; // RULE1 RULE5

   // Read decode; anything not listed answers zero
   always_comb begin
      read_word = ZERO_WORD; // RULE15
      if (in_window) begin
         case (rel_ofs) // RULE4
            OFS_INIT: read_word = {init_reg, {QUAD_MSB{1'b0}}}; // RULE2 RULE5
            OFS_FMT:  read_word = FMT_VAL; // RULE6
            OFS_F0:   read_word = F0_VAL; // RULE7 RULE8
            OFS_F1:   read_word = F1_VAL; // RULE7 RULE9
            OFS_F2:   read_word = F2_VAL; // RULE7 RULE10
            OFS_F7:   read_word = F7_VAL; // RULE7 RULE11
            default:  read_word = ZERO_WORD; // RULE15
         endcase
      end
   end

   // Answer one cycle after each request for this node; writes answer zero
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         rsp_valid <= 1'b0;
      end else begin
         rsp_valid <= req_taken; // RULE3
      end
   end

   // Read data register; write answers carry no data
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         rsp_rdata <= ZERO_WORD;
      end else if (req_taken) begin
         rsp_rdata <= req_write ? ZERO_WORD : read_word; // RULE15
      end
   end

   // Initialize bit: a new write wins over the self clear
   always_comb begin
      init_next = init_reg;
      if (seq_ack) begin
         init_next = 1'b0; // RULE2
      end
      if (init_write) begin
         init_next = 1'b1; // RULE1
      end
   end

   // Initialize bit storage
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         init_reg <= 1'b0;
      end else begin
         init_reg <= init_next;
      end
   end

   // Reinitialisation sequence and startup channel load
   cirb_init_seq u_init_seq (
      .mclk            (mclk),
      .rst_n           (rst_n),
      .start           (init_reg),
      .startup_channel (startup_channel),
      .load_done       (load_done),
      .start_ack       (seq_ack),
      .cam_reset_n     (cam_reset_n),
      .lock_release    (lock_release),
      .load_req        (load_req),
      .load_channel    (load_channel),
      .busy            (init_busy)
   );

   // Checks on the register answers and the initialize bit
   default clocking cb @(posedge mclk); endclocking
   default disable iff (!rst_n);

   // A read of one inquiry offset in this node's window
   sequence rd_at(logic [WIN_BITS-1:0] ofs);
      req_valid && node_hit && !req_write && in_window && rel_ofs == ofs;
   endsequence

   // Initialize write followed by the initialize bit set one cycle later
   sequence init_taken;
      init_write ##1 init_reg;
   endsequence

   AST_ANSWER_ONE_CYCLE: assert property ( // RULE3
      req_valid && node_hit |=> rsp_valid ##1 !rsp_valid || $past(req_valid))
      else $error("Request not answered in one cycle");

   AST_OTHER_NODE_SILENT: assert property ( // RULE3
      !(req_valid && node_hit) |=> !rsp_valid)
      else $error("Answer to a request for another node");

   AST_FORMAT_VALUE: assert property ( // RULE6
      rd_at(OFS_FMT) |=> rsp_rdata == 32'hE100_0000)
      else $error("Format inquiry value wrong");

   AST_F0_VALUE: assert property ( // RULE8
      rd_at(OFS_F0) |=> rsp_rdata == (COLOUR_VARIANT ? 32'h5600_0000 : 32'h4600_0000))
      else $error("Format 0 mode inquiry value wrong");

   AST_F1_VALUE: assert property ( // RULE9
      rd_at(OFS_F1) |=> rsp_rdata == (COLOUR_VARIANT ? 32'hB700_0000 : 32'h2700_0000))
      else $error("Format 1 mode inquiry value wrong");

   AST_F2_VALUE: assert property ( // RULE10
      rd_at(OFS_F2) |=> rsp_rdata == (COLOUR_VARIANT ? 32'hA200_0000 : 32'h2200_0000))
      else $error("Format 2 mode inquiry value wrong");

   AST_F7_VALUE: assert property ( // RULE11
      rd_at(OFS_F7) |=> rsp_rdata[31] && rsp_rdata[30] == COLOUR_VARIANT
                        && rsp_rdata[29:0] == '0)
      else $error("Format 7 mode inquiry value wrong");

   AST_MSB_FIRST: assert property ( // RULE5
      rd_at(OFS_FMT) |=> rsp_rdata[31] && rsp_rdata[24] && !rsp_rdata[25] && !rsp_rdata[0])
      else $error("Bit 0 is not the quadlet MSB");

   AST_UNMAPPED_ZERO: assert property ( // RULE15
      req_valid && node_hit && !in_window |=> rsp_rdata == '0)
      else $error("Unmapped read returned nonzero");

   AST_UNMAPPED_WRITE_NO_INIT: assert property ( // RULE15
      req_valid && node_hit && req_write && !in_window && !init_reg |=> !init_reg)
      else $error("Unmapped write changed the initialize bit");

   AST_INIT_SELF_CLEAR: assert property ( // RULE2
      init_taken ##0 !init_busy |=> !init_reg || init_write)
      else $error("Initialize bit did not clear itself");

   AST_INIT_CLEARS_BOUNDED: assert property ( // RULE2
      init_reg && !init_busy && !init_write |=> !init_reg)
      else $error("Initialize bit held while sequencer idle");

   AST_INIT_STARTS_RESET: assert property ( // RULE1
      init_reg && !init_busy |=> !cam_reset_n ##1 lock_release == 1'b0)
      else $error("Initialize did not reset the camera");

   AST_INIT_RELEASES_LOCK: assert property ( // RULE1
      seq_ack |=> lock_release ##[10:12] load_req)
      else $error("Lock release or reload missing after initialize");

   AST_SET_WINS: assert property ( // RULE2
      init_write && seq_ack |=> init_reg)
      else $error("Initialize write lost against self clear");
endmodule : cirb_top

/* File: include/cirb_pkg.sv */
// Constants, register map and types shared by the inquiry register bank
package cirb_pkg;
   // Clock and reinitialisation timing
   localparam int CLK_PERIOD_NS = 100;
   localparam int CAM_RESET_NS  = 1000;
   localparam int CAM_RESET_CYC = (CAM_RESET_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int CNT_W         = 4;

   // Address layout of a 1394 register request
   localparam int BUS_ID_W  = 10;
   localparam int NODE_ID_W = 6;
   localparam int OFS_W     = 48;
   localparam int WIN_BITS  = 12;
   localparam int CHAN_W    = 2;
   localparam logic [OFS_W-1:0] INQ_BASE = 48'hFFFF_F0F0_0000;

   // Byte offsets from the inquiry base
   localparam logic [WIN_BITS-1:0] OFS_INIT = 12'h000;
   localparam logic [WIN_BITS-1:0] OFS_FMT  = 12'h100;
   localparam logic [WIN_BITS-1:0] OFS_F0   = 12'h180;
   localparam logic [WIN_BITS-1:0] OFS_F1   = 12'h184;
   localparam logic [WIN_BITS-1:0] OFS_F2   = 12'h188;
   localparam logic [WIN_BITS-1:0] OFS_F7   = 12'h19C;

   // Bit 0 is the quadlet MSB, so bit n sits at vector index QUAD_MSB - n
   localparam int QUAD_MSB = 31;
   localparam int INIT_BIT = 0;
   localparam int INIT_POS = QUAD_MSB - INIT_BIT;

   // Inquiry contents, MSB-first bit numbering already applied
   localparam logic [31:0] ZERO_WORD = 32'h0000_0000;
   localparam logic [31:0] FMT_VAL   = 32'hE100_0000;
   localparam logic [31:0] F0_MONO   = 32'h4600_0000;
   localparam logic [31:0] F0_COLOUR = 32'h5600_0000;
   localparam logic [31:0] F1_MONO   = 32'h2700_0000;
   localparam logic [31:0] F1_COLOUR = 32'hB700_0000;
   localparam logic [31:0] F2_MONO   = 32'h2200_0000;
   localparam logic [31:0] F2_COLOUR = 32'hA200_0000;
   localparam logic [31:0] F7_MONO   = 32'h8000_0000;
   localparam logic [31:0] F7_COLOUR = 32'hC000_0000;

   // Protected factory channel
   localparam logic [CHAN_W-1:0] FACTORY_CHANNEL = 2'h0;

   typedef enum logic [1:0] {SEQ_BOOT, SEQ_IDLE, SEQ_RESET, SEQ_LOAD} cirb_seq_state_t;
endpackage : cirb_pkg

/* File: rtl/cirb_rst_sync.sv */
// Reset synchroniser: asynchronous assertion, release through two flops
`timescale 1ns/1ps
module cirb_rst_sync (
   input  wire logic mclk,
   input  wire logic reset_n,
   output logic      rst_n_sync
);
   logic stage1_reg;

   // Flops take only constants under reset; second flop alone reads the first
   always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         stage1_reg <= 1'b0;
         rst_n_sync <= 1'b0;
      end else begin
         stage1_reg <= 1'b1;
         rst_n_sync <= stage1_reg;
      end
   end
endmodule : cirb_rst_sync

/* File: rtl/cirb_init_seq.sv */
// Reinitialisation sequencer: camera reset pulse, lock release, settings load
`timescale 1ns/1ps
module cirb_init_seq
   import cirb_pkg::*;
(
   input  wire logic              mclk,
   input  wire logic              rst_n,
   input  wire logic              start,
   input  wire logic [CHAN_W-1:0] startup_channel,
   input  wire logic              load_done,
   output logic                   start_ack,
   output logic                   cam_reset_n,
   output logic                   lock_release,
   output logic                   load_req,
   output logic [CHAN_W-1:0]      load_channel,
   output logic                   busy
);
   cirb_seq_state_t state_reg;
   logic [CNT_W-1:0] cnt_reg;
   logic [CNT_W-1:0] low_len_reg;

   // Handshakes decoded from state
   assign start_ack = (state_reg == SEQ_IDLE) && start;
   assign load_req  = (state_reg == SEQ_LOAD);
   assign busy      = (state_reg != SEQ_IDLE);

   // Sequence: boot load, then reset pulse and load on each request
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         state_reg <= SEQ_BOOT;
      end else begin
         case (state_reg)
            SEQ_BOOT:  state_reg <= SEQ_LOAD;
            SEQ_IDLE:  if (start) state_reg <= SEQ_RESET;
            SEQ_RESET: if (cnt_reg == '0) state_reg <= SEQ_LOAD;
            SEQ_LOAD:  if (load_done) state_reg <= SEQ_IDLE;
            default:   state_reg <= SEQ_IDLE;
         endcase
      end
   end

   // Reset pulse width counter and pulse output
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         cnt_reg     <= '0;
         cam_reset_n <= 1'b1;
      end else if (start_ack) begin
         cnt_reg     <= CNT_W'(CAM_RESET_CYC - 1);
         cam_reset_n <= 1'b0; // RULE1
      end else if (state_reg == SEQ_RESET) begin
         cnt_reg <= cnt_reg - 1'b1;
         if (cnt_reg == '0) begin
            cam_reset_n <= 1'b1;
         end
      end
   end

   // One-cycle lock release with each reinitialisation
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         lock_release <= 1'b0;
      end else begin
         lock_release <= start_ack; // RULE1
      end
   end

   // Startup channel is caught at boot and at each reinitialisation
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         load_channel <= FACTORY_CHANNEL; // RULE16
      end else if (state_reg == SEQ_BOOT || start_ack) begin
         load_channel <= startup_channel; // RULE16
      end
   end

   // Helper for checks: length of the reset pulse
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         low_len_reg <= '0;
      end else if (!cam_reset_n) begin
         low_len_reg <= low_len_reg + 1'b1;
      end else begin
         low_len_reg <= '0;
      end
   end

   AST_RESET_WIDTH: assert property (@(posedge mclk) disable iff (!rst_n) // RULE1
      $rose(cam_reset_n) |-> low_len_reg == CNT_W'(CAM_RESET_CYC))
      else $error("Camera reset pulse has wrong width");

   AST_LOAD_HOLD: assert property (@(posedge mclk) disable iff (!rst_n) // RULE16
      load_req && !load_done |=> load_req && $stable(load_channel))
      else $error("Settings load dropped or channel moved");

   AST_RESET_THEN_LOAD: assert property (@(posedge mclk) disable iff (!rst_n) // RULE1
      $rose(cam_reset_n) |-> load_req)
      else $error("Load did not follow camera reset");
endmodule : cirb_init_seq

/* File: verification/cirb_store_model.sv */
// Settings store model that answers load requests after a set delay
`timescale 1ns/1ps
module cirb_store_model #(
   parameter int DELAY = 3
) (
   input  wire logic mclk,
   input  wire logic reset_n,
   input  wire logic load_req,
   output logic      load_done
);
   int cnt;

   // Counts the load time, then pulses done for exactly one cycle
   always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         cnt       <= 0;
         load_done <= 1'b0;
      end else if (!load_req || load_done) begin
         cnt       <= 0;
         load_done <= 1'b0;
      end else if (cnt == DELAY) begin
         load_done <= 1'b1;
      end else begin
         cnt <= cnt + 1;
      end
   end
endmodule : cirb_store_model

/* File: verification/cirb_top_tb.sv */
// Self-checking bench for both variants of the inquiry register bank
`timescale 1ns/1ps
module cirb_top_tb;
   import cirb_pkg::*;
   localparam logic [BUS_ID_W-1:0]  MY_BUS  = 10'h155;
   localparam logic [NODE_ID_W-1:0] MY_NODE = 6'h05;
   logic                 mclk;
   logic                 reset_n;
   logic                 req_valid;
   logic                 req_write;
   logic [NODE_ID_W-1:0] req_node_id;
   logic [OFS_W-1:0]     req_offset;
   logic [31:0]          req_wdata;
   logic [CHAN_W-1:0]    startup_channel;
   logic [1:0]           rsp_valid;
   logic [1:0]           cam_reset_n;
   logic [1:0]           lock_release;
   logic [1:0]           load_req;
   logic [1:0]           load_done;
   logic [1:0]           init_busy;
   logic [31:0]          rsp_rdata [2];
   logic [CHAN_W-1:0]    load_channel [2];
   int                   miscompares;
   int                   comparisons;
   int                   low_cycles;
   int                   release_pulses;

   // One monochrome and one colour bank, each with its own settings store
   for (genvar v = 0; v < 2; v++) begin : g_var
      cirb_top #(.COLOUR_VARIANT(v == 1)) cirb_top_i (
         .mclk(mclk), .reset_n(reset_n), .local_bus_id(MY_BUS), .local_node_id(MY_NODE),
         .req_valid(req_valid), .req_write(req_write), .req_bus_id(MY_BUS),
         .req_node_id(req_node_id), .req_offset(req_offset), .req_wdata(req_wdata),
         .startup_channel(startup_channel), .load_done(load_done[v]),
         .rsp_valid(rsp_valid[v]), .rsp_rdata(rsp_rdata[v]), .cam_reset_n(cam_reset_n[v]),
         .lock_release(lock_release[v]), .load_req(load_req[v]),
         .load_channel(load_channel[v]), .init_busy(init_busy[v]));
      cirb_store_model #(.DELAY(3 + 4 * v)) cirb_store_model_i (
         .mclk(mclk), .reset_n(reset_n), .load_req(load_req[v]), .load_done(load_done[v]));
   end

   // Free-running control clock
   initial begin
      mclk = 1'b0;
      forever #(CLK_PERIOD_NS / 2) mclk = ~mclk;
   end

   // Counts camera reset low cycles and lock release pulses
   always @(posedge mclk) begin
      if (cam_reset_n[0] === 1'b0) low_cycles++;
      if (lock_release[0] === 1'b1) release_pulses++;
   end

   task automatic complete_run();
      $display("comparisons %0d miscompares %0d", comparisons, miscompares);
      if (miscompares == 0 && comparisons > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask : complete_run

   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      comparisons++;
      if (seen !== exp) begin
         miscompares++;
         $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask : check

   // One quadlet request, strobe held for one edge, address scrambled after
   task automatic access(input logic wr, input logic [WIN_BITS-1:0] ofs,
                         input logic [31:0] wd, input logic [NODE_ID_W-1:0] node,
                         input logic [OFS_W-1:0] base);
      @(posedge mclk);
      #1;
      req_valid   = 1'b1;
      req_write   = wr;
      req_node_id = node;
      req_offset  = base + {36'h0, ofs};
      req_wdata   = wd;
      @(posedge mclk);
      #1;
      req_valid  = 1'b0;
      req_offset = ~req_offset;
      req_wdata  = ~req_wdata;
   endtask : access

   // Reads one offset from both variants and compares the answers
   task automatic rd(input logic [WIN_BITS-1:0] ofs, input logic [31:0] em,
                     input logic [31:0] ec, input logic [OFS_W-1:0] base = INQ_BASE);
      access(1'b0, ofs, 32'h0000_0000, MY_NODE, base);
      check({30'h0, rsp_valid}, 32'h0000_0003);
      check(rsp_rdata[0], em);
      check(rsp_rdata[1], ec);
   endtask : rd

   task automatic wait_idle();
      for (int i = 0; i < 300 && init_busy !== 2'b00; i++) @(posedge mclk);
      #1;
      check({30'h0, init_busy}, 32'h0000_0000);
   endtask : wait_idle

   // Watchdog sized well beyond the test sequence
   initial begin
      #(CLK_PERIOD_NS * 3000);
      miscompares++;
      complete_run();
   end

   initial begin
      reset_n         = 1'b0;
      req_valid       = 1'b0;
      req_write       = 1'b0;
      req_node_id     = MY_NODE;
      req_offset      = 48'h0000_0000_0000;
      req_wdata       = 32'h0000_0000;
      startup_channel = 2'h0;
      miscompares     = 0;
      comparisons     = 0;
      repeat (5) @(posedge mclk);
      #1;
      reset_n = 1'b1;
      wait_idle();
      check({30'h0, load_channel[0]}, 32'h0000_0000);
      rd(12'h100, 32'hE100_0000, 32'hE100_0000);
      rd(12'h180, 32'h4600_0000, 32'h5600_0000);
      rd(12'h184, 32'h2700_0000, 32'hB700_0000);
      rd(12'h188, 32'h2200_0000, 32'hA200_0000);
      rd(12'h19C, 32'h8000_0000, 32'hC000_0000);
      rd(12'h104, 32'h0000_0000, 32'h0000_0000);
      rd(12'h182, 32'h0000_0000, 32'h0000_0000);
      rd(12'hFFC, 32'h0000_0000, 32'h0000_0000);
      rd(12'h100, 32'h0000_0000, 32'h0000_0000, INQ_BASE + 48'h1000);
      access(1'b0, 12'h100, 32'h0000_0000, MY_NODE + 6'h01, INQ_BASE);
      check({30'h0, rsp_valid}, 32'h0000_0000);
      access(1'b1, 12'h100, 32'h0000_0000, MY_NODE, INQ_BASE);
      check(rsp_rdata[0], 32'h0000_0000);
      rd(12'h100, 32'hE100_0000, 32'hE100_0000);
      access(1'b1, 12'h000, 32'h7FFF_FFFF, MY_NODE, INQ_BASE);
      repeat (3) @(posedge mclk);
      #1;
      check({30'h0, init_busy}, 32'h0000_0000);
      startup_channel = 2'h2;
      low_cycles      = 0;
      release_pulses  = 0;
      access(1'b1, 12'h000, 32'h8000_0000, MY_NODE, INQ_BASE);
      @(posedge mclk);
      #1;
      check({30'h0, init_busy}, 32'h0000_0003);
      check({30'h0, cam_reset_n}, 32'h0000_0000);
      rd(12'h000, 32'h0000_0000, 32'h0000_0000);
      wait_idle();
      check(low_cycles, CAM_RESET_CYC);
      check(release_pulses, 32'h0000_0001);
      check({30'h0, load_channel[0]}, 32'h0000_0002);
      check({30'h0, load_channel[1]}, 32'h0000_0002);
      rd(12'h000, 32'h0000_0000, 32'h0000_0000);
      rd(12'h19C, 32'h8000_0000, 32'hC000_0000);
      complete_run();
   end
endmodule : cirb_top_tb
